// ---- inc/pms_regs.svh ----
// register offsets, field positions, reset values and codes of the mirror probe selector
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// register map: three probes of four words each, then global words
`define PMS_NPROBE         3
`define PMS_OFF_FILTER     2'h0
`define PMS_OFF_PMASK      2'h1
`define PMS_OFF_PMASK_HI   2'h2
`define PMS_OFF_COPY       2'h3
`define PMS_ADDR_GLOBAL    8'h30
`define PMS_ADDR_STATUS    8'h34

// probe_filter_config fields
`define PMS_DIR_TX_BIT     0
`define PMS_DIR_RX_BIT     1
`define PMS_STN_DST_BIT    2
`define PMS_STN_SRC_BIT    3
`define PMS_VMODE_LSB      4
`define PMS_PHYS_BIT       6
`define PMS_CPU_LSB        8
`define PMS_RXCPU_LSB      12
`define PMS_VID_LSB        16
`define PMS_FILT_FIXED     32'h0FFF007F

// probe_copy_forward_config fields
`define PMS_DEST_LSB       0
`define PMS_QTAG_BIT       8
`define PMS_TXP_LSB        16
`define PMS_COPY_KEEP      32'h007F017F

// global word fields
`define PMS_FLOOD_BIT      0

// reset value of every register
`define PMS_RST_WORD       32'h00000000

// bus responses
`define PMS_RESP_OKAY      2'h0
`define PMS_RESP_SLVERR    2'h2

`endif

// ---- inc/pms_pkg.sv ----
// types shared by the mirror probe selector
package pms_pkg;
  // vlan filter modes, in field order
  typedef enum logic [1:0] {
    PMS_VLAN_ANY,
    PMS_VLAN_FLAG,
    PMS_VLAN_VID,
    PMS_VLAN_RSVD
  } pms_vlan_mode_t;
endpackage

// ---- core/pms_probe_match.sv ----
// filter evaluation of one mirror probe against one frame
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"

module pms_probe_match #(
  parameter int NPORT  = 11, // front ports
  parameter int NCPU   = 2,  // cpu ports
  parameter int NCPUVD = 4,  // cpu and virtual device sources
  parameter int PIDX_W = 7   // port index width
) (
  input  wire logic [31:0]       cfg,       // probe_filter_config
  input  wire logic [63:0]       pmask,     // port mask, both words
  input  wire logic              flood_en,  // flooded_copy_enable
  input  wire logic [PIDX_W-1:0] phys_port, // physical ingress port
  input  wire logic [PIDX_W-1:0] masq_port, // masqueraded ingress port
  input  wire logic [NCPUVD-1:0] rx_cpuvd,  // cpu or virtual source, zero for front
  input  wire logic [NPORT-1:0]  dst_ports, // egress front ports
  input  wire logic [NCPU-1:0]   dst_cpus,  // destination cpu ports
  input  wire logic [11:0]       vid,       // classified vlan id
  input  wire logic              vlan_flag, // vlan_entry_copy_flag of the vlan
  input  wire logic              src_flag,  // source learned with mirror flag
  input  wire logic              dst_flag,  // destination learned with mirror flag
  input  wire logic              flooded,   // frame is flooded
  input  wire logic              acl_sel,   // classifier picked this probe
  output logic                   hit,       // probe wants a copy
  output logic                   rx_copy    // copy is of the receive kind
);
  logic [1:0]              dir;      // direction field
  logic [PIDX_W-1:0]       rx_port;  // port compared for receive
  logic                    rx_front; // receive front port selected
  logic                    rx_hit;   // receive direction matches
  logic                    tx_hit;   // transmit direction matches
  logic                    vlan_ok;  // vlan condition holds
  logic                    stn_ok;   // station condition holds
  logic                    acl_hit;  // classifier path matches
  pms_pkg::pms_vlan_mode_t vmode;    // vlan filter mode

  assign dir   = cfg[`PMS_DIR_RX_BIT:`PMS_DIR_TX_BIT];
  assign vmode = pms_pkg::pms_vlan_mode_t'(cfg[`PMS_VMODE_LSB +: 2]);
  // physical or masqueraded ingress port
  assign rx_port  = cfg[`PMS_PHYS_BIT] ? phys_port : masq_port;
  // front port ingress against port mask, one bit per port
  assign rx_front = (rx_cpuvd == '0) && (rx_port < PIDX_W'(NPORT)) && pmask[rx_port[5:0]];
  // receive: front port or cpu and virtual sources
  assign rx_hit = cfg[`PMS_DIR_RX_BIT] &
                  (rx_front | (|(rx_cpuvd & cfg[`PMS_RXCPU_LSB +: NCPUVD])));
  // transmit: egress ports or destination cpu ports
  assign tx_hit = cfg[`PMS_DIR_TX_BIT] &
                  ((|(dst_ports & pmask[NPORT-1:0])) | (|(dst_cpus & cfg[`PMS_CPU_LSB +: NCPU])));
  // station flags; every enabled bit must hold
  assign stn_ok = (~cfg[`PMS_STN_SRC_BIT] | src_flag) &
                  (~cfg[`PMS_STN_DST_BIT] | dst_flag | (flooded & flood_en));
  // classifier path only looks at direction
  assign acl_hit = acl_sel & (dir != 2'h0);

  // vlan condition per mode
  always_comb begin
    case (vmode)
      pms_pkg::PMS_VLAN_FLAG: vlan_ok = vlan_flag;
      pms_pkg::PMS_VLAN_VID:  vlan_ok = (vid == cfg[`PMS_VID_LSB +: 12]);
      default:                vlan_ok = 1'b1;
    endcase
  end

  // all enabled conditions together, or the classifier path
  assign hit     = ((rx_hit | tx_hit) & vlan_ok & stn_ok) | acl_hit;
  assign rx_copy = rx_hit | (acl_hit & dir[`PMS_DIR_RX_BIT]);
endmodule
`default_nettype wire

// ---- core/pms_top.sv ----
// mirror probe selector: three probes, priority pick, axi4-lite registers
// Contract
// - three independent probes, own filter sets
// - all enabled probe conditions must hold
// - highest matching probe wins, one copy
// - rx direction: ingress front ports in mask
// - tx direction: egress ports in mask
// - tx direction: destination cpu ports selected
// - vlan mode 2: vid must equal
// - vlan mode 1: vlan entry flag set
// - station bit1: source learned with flag
// - station bit0: destination flagged or flooded
// - classifier-picked frames check direction only
// - rx direction: cpu and virtual sources masked
// - per-probe physical or masqueraded ingress port
// - copy goes to probe destination port
// - rx copies unmodified, optional extra q-tag
// - tx copies edited as tx port
// - direction 2 is rx; mask bit per port
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"

module pms_top #(
  parameter int NPORT  = 11, // front ports
  parameter int NCPU   = 2,  // cpu ports
  parameter int NCPUVD = 4,  // cpu and virtual device sources
  parameter int PIDX_W = 7   // port index width
) (
  input  wire logic              ref_clk,         // core clock
  input  wire logic              rst,             // async reset, high
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,    // write address
  input  wire logic              s_axi_awvalid,   // write address valid
  output var  logic              s_axi_awready,   // write address ready
  input  wire logic [31:0]       s_axi_wdata,     // write data
  input  wire logic [3:0]        s_axi_wstrb,     // write byte strobes
  input  wire logic              s_axi_wvalid,    // write data valid
  output var  logic              s_axi_wready,    // write data ready
  output var  logic [1:0]        s_axi_bresp,     // write response
  output var  logic              s_axi_bvalid,    // write response valid
  input  wire logic              s_axi_bready,    // write response ready
  input  wire logic [7:0]        s_axi_araddr,    // read address
  input  wire logic              s_axi_arvalid,   // read address valid
  output var  logic              s_axi_arready,   // read address ready
  output var  logic [31:0]       s_axi_rdata,     // read data
  output var  logic [1:0]        s_axi_rresp,     // read response
  output var  logic              s_axi_rvalid,    // read data valid
  input  wire logic              s_axi_rready,    // read data ready
  // frame attributes from the analyzer
  input  wire logic              frm_valid,       // attributes valid, one cycle
  input  wire logic [PIDX_W-1:0] frm_phys_port,   // physical ingress port
  input  wire logic [PIDX_W-1:0] frm_masq_port,   // masqueraded ingress port
  input  wire logic [NCPUVD-1:0] frm_rx_cpuvd,    // cpu or virtual source
  input  wire logic [NPORT-1:0]  frm_dst_ports,   // egress front ports
  input  wire logic [NCPU-1:0]   frm_dst_cpus,    // destination cpu ports
  input  wire logic [11:0]       frm_vid,         // classified vlan id
  input  wire logic              frm_vlan_flag,   // vlan_entry_copy_flag
  input  wire logic              frm_src_flag,    // source station flag
  input  wire logic              frm_dst_flag,    // destination station flag
  input  wire logic              frm_flooded,     // flooded frame
  input  wire logic [2:0]        frm_acl_probe,   // classifier probe picks
  // mirror decision to queue forwarding and rewriter
  output var  logic              mir_valid,       // decision valid, one cycle
  output var  logic              mir_copy,        // make one copy
  output var  logic [1:0]        mir_probe,       // probe that decided
  output var  logic [PIDX_W-1:0] mir_dest_port,   // copy_destination_port
  output var  logic              mir_rx_copy,     // send as received
  output var  logic [PIDX_W-1:0] mir_tx_port,     // port to edit as, tx copies
  output var  logic              mir_add_qtag     // add remote mirror q-tag
);
  localparam int NPROBE = `PMS_NPROBE; // probe count

  // parameter checks
  if (NPORT < 1 || NPORT > 64) begin : g_bad_nport
    $error("NPORT must be 1 to 64");
  end
  if (NCPU < 1 || NCPU > 4 || NCPUVD < 1 || NCPUVD > 4) begin : g_bad_ncpu
    $error("NCPU and NCPUVD must be 1 to 4");
  end
  if (PIDX_W != 7) begin : g_bad_pidx
    $error("PIDX_W must be 7");
  end

  // writable bits of the port mask and filter words
  localparam logic [63:0] PM_KEEP   = (NPORT == 64) ? 64'hFFFFFFFFFFFFFFFF :
                                      ((64'h1 << NPORT) - 64'h1);
  localparam logic [31:0] FILT_KEEP = `PMS_FILT_FIXED |
                                      (((32'h1 << NCPUVD) - 32'h1) << `PMS_RXCPU_LSB) |
                                      (((32'h1 << NCPU) - 32'h1) << `PMS_CPU_LSB);

  logic [31:0]       cfg_reg     [NPROBE]; // probe_filter_config
  logic [31:0]       pmask_reg   [NPROBE]; // probe_port_mask
  logic [31:0]       pmask_hi_reg[NPROBE]; // probe_port_mask_upper
  logic [31:0]       copy_reg    [NPROBE]; // probe_copy_forward_config
  logic              flood_reg;            // flooded_copy_enable
  logic [15:0]       cnt_reg;              // copies made, wraps
  logic [7:0]        awaddr_reg;           // held write address
  logic [31:0]       wdata_reg;            // held write data
  logic [3:0]        wstrb_reg;            // held write strobes
  logic              do_write;             // both halves held, no response out
  logic [4:0]        wdec;                 // decoded write address
  logic [NPROBE-1:0] hit;                  // per probe match
  logic [NPROBE-1:0] rxk;                  // per probe copy kind
  logic              sel_any;              // some probe matched
  logic [1:0]        sel_idx;              // highest matching probe

  // address decode: [4] probe word, [3:2] probe, [1:0] word
  function automatic logic [4:0] pms_decode(input logic [7:0] a);
    pms_decode = {(a < `PMS_ADDR_GLOBAL) && (a[1:0] == 2'h0), a[5:4], a[3:2]};
  endfunction

  // byte strobe merge
  function automatic logic [31:0] pms_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
    pms_merge = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        pms_merge[8*b +: 8] = new_w[8*b +: 8];
      end
    end
  endfunction

  // read mux, {error, data}
  function automatic logic [32:0] pms_read(input logic [7:0] a);
    logic [4:0] d;
    d = pms_decode(a);
    pms_read = {1'b0, `PMS_RST_WORD};
    if (d[4]) begin
      case (d[1:0])
        `PMS_OFF_FILTER:   pms_read = {1'b0, cfg_reg[d[3:2]]};
        `PMS_OFF_PMASK:    pms_read = {1'b0, pmask_reg[d[3:2]]};
        `PMS_OFF_PMASK_HI: pms_read = {1'b0, pmask_hi_reg[d[3:2]]};
        default:           pms_read = {1'b0, copy_reg[d[3:2]]};
      endcase
    end else if (a == `PMS_ADDR_GLOBAL) begin
      pms_read = {1'b0, 31'h0, flood_reg};
    end else if (a == `PMS_ADDR_STATUS) begin
      pms_read = {1'b0, cnt_reg, 13'h0, mir_copy, mir_probe};
    end else begin
      pms_read = {1'b1, `PMS_RST_WORD};
    end
  endfunction

  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wdec     = pms_decode(awaddr_reg);

  // write address channel: take once, reopen after the response
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awaddr_reg    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel: independent of the address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= `PMS_RST_WORD;
      wstrb_reg    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response: unmapped addresses answer slverr
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wdec[4] || awaddr_reg == `PMS_ADDR_GLOBAL ||
                       awaddr_reg == `PMS_ADDR_STATUS) ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // probe register file, one set of four words per probe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NPROBE; i++) begin
        cfg_reg[i]      <= `PMS_RST_WORD;
        pmask_reg[i]    <= `PMS_RST_WORD;
        pmask_hi_reg[i] <= `PMS_RST_WORD;
        copy_reg[i]     <= `PMS_RST_WORD;
      end
    end else if (do_write && wdec[4]) begin
      case (wdec[1:0])
        // reserved bits stay zero
        `PMS_OFF_FILTER: begin
          cfg_reg[wdec[3:2]] <= pms_merge(cfg_reg[wdec[3:2]], wdata_reg, wstrb_reg) & FILT_KEEP;
        end
        // bits above the last port stay zero
        `PMS_OFF_PMASK: begin
          pmask_reg[wdec[3:2]] <= pms_merge(pmask_reg[wdec[3:2]], wdata_reg, wstrb_reg) &
                                  PM_KEEP[31:0];
        end
        `PMS_OFF_PMASK_HI: begin
          pmask_hi_reg[wdec[3:2]] <= pms_merge(pmask_hi_reg[wdec[3:2]], wdata_reg,
                                               wstrb_reg) & PM_KEEP[63:32];
        end
        default: begin
          copy_reg[wdec[3:2]] <= pms_merge(copy_reg[wdec[3:2]], wdata_reg, wstrb_reg) &
                                 `PMS_COPY_KEEP;
        end
      endcase
    end
  end

  // global word: flood copy enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flood_reg <= 1'b0;
    end else if (do_write && awaddr_reg == `PMS_ADDR_GLOBAL && wstrb_reg[0]) begin
      flood_reg <= wdata_reg[`PMS_FLOOD_BIT];
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PMS_RST_WORD;
      s_axi_rresp   <= `PMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      {s_axi_rresp[1], s_axi_rdata} <= pms_read(s_axi_araddr); // error bit marks slverr
      s_axi_rresp[0] <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // one filter evaluator per probe
  for (genvar p = 0; p < NPROBE; p++) begin : g_probe
    pms_probe_match #(
      .NPORT  (NPORT),
      .NCPU   (NCPU),
      .NCPUVD (NCPUVD),
      .PIDX_W (PIDX_W)
    ) u_match (
      .cfg       (cfg_reg[p]),
      .pmask     ({pmask_hi_reg[p], pmask_reg[p]}),
      .flood_en  (flood_reg),
      .phys_port (frm_phys_port),
      .masq_port (frm_masq_port),
      .rx_cpuvd  (frm_rx_cpuvd),
      .dst_ports (frm_dst_ports),
      .dst_cpus  (frm_dst_cpus),
      .vid       (frm_vid),
      .vlan_flag (frm_vlan_flag),
      .src_flag  (frm_src_flag),
      .dst_flag  (frm_dst_flag),
      .flooded   (frm_flooded),
      .acl_sel   (frm_acl_probe[p]),
      .hit       (hit[p]),
      .rx_copy   (rxk[p])
    );
  end

  // priority pick: later probes overwrite, so the highest wins
  always_comb begin
    sel_any = 1'b0;
    sel_idx = 2'h0;
    for (int i = 0; i < NPROBE; i++) begin
      if (hit[i]) begin
        sel_any = 1'b1;
        sel_idx = i[1:0];
      end
    end
  end

  // registered decision, one per frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mir_valid     <= 1'b0;
      mir_copy      <= 1'b0;
      mir_probe     <= 2'h0;
      mir_dest_port <= '0;
      mir_rx_copy   <= 1'b0;
      mir_tx_port   <= '0;
      mir_add_qtag  <= 1'b0;
    end else begin
      mir_valid <= frm_valid;
      if (frm_valid) begin
        // no match leaves every copy field quiet
        mir_copy      <= sel_any;
        mir_probe     <= sel_idx;
        mir_dest_port <= sel_any ? copy_reg[sel_idx][`PMS_DEST_LSB +: PIDX_W] : '0;
        mir_rx_copy   <= sel_any & rxk[sel_idx];
        mir_tx_port   <= (sel_any & ~rxk[sel_idx]) ?
                         copy_reg[sel_idx][`PMS_TXP_LSB +: PIDX_W] : '0;
        mir_add_qtag  <= sel_any & copy_reg[sel_idx][`PMS_QTAG_BIT];
      end
    end
  end

  // copy counter shown in the status word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else if (frm_valid && sel_any) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // checks on the decision path and the bus channels
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  highest_probe_a: assert property (frm_valid && hit[2] |=> mir_copy && mir_probe == 2'h2)
    else $error("highest probe not selected");
  middle_probe_a: assert property (frm_valid && hit[1] && !hit[2] |=> mir_probe == 2'h1)
    else $error("middle probe not selected");
  no_match_a: assert property (frm_valid && hit == 3'h0 |=> !mir_copy && !mir_add_qtag)
    else $error("copy made without a match");
  dest_port_a: assert property (frm_valid && hit[0] && hit[2:1] == 2'h0
                               |=> mir_dest_port == $past(copy_reg[0][6:0]))
    else $error("copy sent to wrong port");
  dir_off_a: assert property (frm_valid && cfg_reg[2][1:0] == 2'h0 |-> !hit[2])
    else $error("probe with no direction matched");
  vid_filter_a: assert property (frm_valid && cfg_reg[1][5:4] == 2'h2 &&
                                 !frm_acl_probe[1] && frm_vid != cfg_reg[1][27:16] |-> !hit[1])
    else $error("vid filter let a frame through");
  acl_dir_a: assert property (frm_valid && frm_acl_probe[1] && cfg_reg[1][1:0] != 2'h0
                              |-> hit[1])
    else $error("classifier pick ignored");
  rx_mask_a: assert property (frm_valid && cfg_reg[1][6:0] == 7'h62 &&
                              pmask_reg[1] == 32'h00000008 && frm_rx_cpuvd == '0 &&
                              frm_phys_port == 7'h03 && frm_vid == cfg_reg[1][27:16] |-> hit[1])
    else $error("rx port 3 not mirrored");
  tx_edit_a: assert property (frm_valid && hit[2] && !rxk[2] |=> !mir_rx_copy &&
                              mir_tx_port == $past(copy_reg[2][22:16]))
    else $error("tx copy not edited as tx port");
  one_decision_a: assert property (frm_valid |=> mir_valid ##1 (mir_valid == $past(frm_valid)))
    else $error("decision not one per frame");
  count_step_a: assert property (frm_valid && sel_any |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("copy counter did not step");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  rx_copy_c: cover property (mir_valid && mir_copy && mir_rx_copy);
  tx_copy_c: cover property (mir_valid && mir_copy && !mir_rx_copy);
  multi_hit_c: cover property (frm_valid && hit == 3'h7);
  write_done_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
endmodule
`default_nettype wire

// ---- tb/pms_fwd_model.sv ----
// far side model: queue forwarding counting the copies it is handed
`timescale 1ns/1ps
`default_nettype none
module pms_fwd_model (
  input  wire logic       ref_clk,   // core clock
  input  wire logic       rst,       // async reset, high
  input  wire logic       mir_valid, // decision pulse
  input  wire logic       mir_copy,  // copy wanted
  output var  logic [7:0] copies     // copies taken so far
);
  // one copy per decision at most, never one without a decision
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) copies <= 8'h00;
    else if (mir_valid && mir_copy) copies <= copies + 8'h01;
  end
endmodule
`default_nettype wire

// ---- tb/pms_top_tb_top.sv ----
// self-checking bench of the mirror probe selector
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"
module pms_top_tb_top;
  logic        ref_clk, rst;                      // clock, reset
  logic [7:0]  awaddr, araddr, copies;            // addresses, copy count
  logic [31:0] wdata, rdata;                      // bus data
  logic [1:0]  bresp, rresp, dc, mp;              // responses, cpus, probe
  logic        awv, awr, wv, wrdy, bv, br;        // write handshakes
  logic        arv, arr, rv, rr;                  // read handshakes
  logic        fv, vf, sf, df, fl, mv, mc, mrx, mqt; // frame strobes and flags
  logic [3:0]  cv;                                // cpu or virtual source
  logic [6:0]  ph, mq, md, mtx;                   // port indices
  logic [10:0] dp;                                // egress ports
  logic [11:0] vid;                               // vlan id
  logic [2:0]  acl;                               // classifier picks
  int          miscompares = 0;                   // mismatches
  int          comparisons = 0;                   // checks made
  pms_top dut_u (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .frm_valid(fv),
    .frm_phys_port(ph), .frm_masq_port(mq), .frm_rx_cpuvd(cv), .frm_dst_ports(dp),
    .frm_dst_cpus(dc), .frm_vid(vid), .frm_vlan_flag(vf), .frm_src_flag(sf),
    .frm_dst_flag(df), .frm_flooded(fl), .frm_acl_probe(acl), .mir_valid(mv),
    .mir_copy(mc), .mir_probe(mp), .mir_dest_port(md), .mir_rx_copy(mrx),
    .mir_tx_port(mtx), .mir_add_qtag(mqt));
  pms_fwd_model fwd_u (.ref_clk(ref_clk), .rst(rst), .mir_valid(mv), .mir_copy(mc),
    .copies(copies));
  // free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // bus write: each channel released when taken, then wait for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    {awaddr, wdata, awv, wv, br} <= {a, d, 3'h7};
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wrdy));
    do @(posedge ref_clk); while (!bv);
    chk(32'(bresp), 32'(e));
    br <= 1'b0;
    @(posedge ref_clk);
  endtask
  // bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    {araddr, arv, rr} <= {a, 2'h3};
    do @(posedge ref_clk); while (!arr);
    arv <= 1'b0;
    do @(posedge ref_clk); while (!rv);
    chk(rdata, d);
    chk(32'(rresp), 32'(e));
    rr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one frame; e is {copy, probe, rx kind, 1'b0, dest port}
  task automatic frame(input logic [6:0] p, m, input logic [10:0] d, input logic [1:0] c,
      input logic [11:0] v, input logic [1:0] fs, input logic [2:0] a, input logic [11:0] e);
    {ph, mq, dp, dc, vid, vf, sf, acl, fv} <= {p, m, d, c, v, fs, a, 1'b1};
    @(posedge ref_clk);
    fv <= 1'b0;
    @(posedge ref_clk);
    chk(32'({mv, mc, e[11] ? mp : 2'h0, mrx, md}), 32'({1'b1, e[11:8], e[6:0]}));
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {rst, awv, wv, br, arv, rr, fv} = 7'h40;
    {awaddr, araddr, wdata, ph, mq, dp, dc, vid, vf, sf, acl, cv, df, fl} = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h20, 32'h00000000, 2'h0);
    rd(8'h40, 32'h00000000, `PMS_RESP_SLVERR);
    wr(8'h40, 32'h00000001, `PMS_RESP_SLVERR);
    // probe 1: rx only, vid 3, physical port 3, copy to port 11
    wr(8'h10, 32'h00030062, 2'h0);
    rd(8'h10, 32'h00030062, 2'h0);
    wr(8'h14, 32'h00000008, 2'h0);
    wr(8'h1C, 32'h0000000B, 2'h0);
    frame(7'h03, 7'h03, 11'h000, 2'h0, 12'h003, 2'h0, 3'h0, 12'hB0B);
    frame(7'h03, 7'h03, 11'h000, 2'h0, 12'h004, 2'h0, 3'h0, 12'h000);
    frame(7'h02, 7'h03, 11'h000, 2'h0, 12'h003, 2'h0, 3'h0, 12'h000);
    // probe 2: tx on port 5, edited as port 4 with q-tag, copy to port 7
    wr(8'h20, 32'h00000001, 2'h0);
    wr(8'h24, 32'h00000020, 2'h0);
    wr(8'h2C, 32'h00040107, 2'h0);
    frame(7'h03, 7'h03, 11'h020, 2'h0, 12'h003, 2'h0, 3'h0, 12'hC07);
    chk(32'({mtx, mqt}), 32'({7'h04, 1'b1}));
    wr(8'h0C, 32'hFFFFFFFF, 2'h0);
    rd(8'h0C, `PMS_COPY_KEEP, 2'h0);
    wr(8'h0C, 32'h00000002, 2'h0);
    // probe 0: tx to cpu 0, after a classifier pick of probe 1
    wr(8'h00, 32'h00000101, 2'h0);
    frame(7'h00, 7'h00, 11'h000, 2'h0, 12'h000, 2'h0, 3'h2, 12'hB0B);
    frame(7'h00, 7'h00, 11'h000, 2'h1, 12'h000, 2'h0, 3'h0, 12'h802);
    // probe 0: rx on masqueraded port 0, vlan flag and source station flag
    wr(8'h00, 32'h0000001A, 2'h0);
    wr(8'h04, 32'h00000001, 2'h0);
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h3, 3'h0, 12'h902);
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h2, 3'h0, 12'h000);
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h1, 3'h0, 12'h000);
    // probe 0: rx on port 0 to flagged stations, and from cpu source 0
    wr(8'h00, 32'h00001006, 2'h0);
    {cv, df, fl} <= 6'h02;
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h0, 3'h0, 12'h902);
    {cv, df, fl} <= 6'h01;
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h0, 3'h0, 12'h000);
    wr(8'h30, 32'h00000001, 2'h0);
    frame(7'h09, 7'h00, 11'h000, 2'h0, 12'h000, 2'h0, 3'h0, 12'h902);
    {cv, df, fl} <= 6'h06;
    frame(7'h09, 7'h09, 11'h000, 2'h0, 12'h000, 2'h0, 3'h0, 12'h902);
    {cv, df, fl} <= 6'h0A;
    frame(7'h09, 7'h09, 11'h000, 2'h0, 12'h000, 2'h0, 3'h0, 12'h000);
    chk(32'(copies), 32'h00000008);
    report_and_stop;
  end
endmodule
`default_nettype wire
